// *** core/sysref_capture_control.sv ***
// Alignment strobe capture control with Wishbone register access
`timescale 1ns/1ps
module sysref_capture_control (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire sysref_pkg::wb_req_type wb_i,
   output sysref_pkg::wb_rsp_type wb_o,
   input wire logic sysref_i,
   input wire logic conv_clk_i,
   output logic capture_o,
   output logic irq_o
);
   import sysref_pkg::*;

   setup_type cfg;
   logic [3:0] ignore_cnt;
   logic [1:0] skew_neg;
   logic [1:0] skew_pos;
   logic [EVT_N-1:0] irq_stat;
   logic [EVT_N-1:0] irq_mask;
   logic [1:0] pins_s;
   logic sysref_s;
   logic conv_s;
   logic conv_d;
   logic samp_en;
   logic sref_prev;
   logic transition;
   cap_state_type st;
   logic [3:0] ign_left;
   logic cap;
   logic [PHASE_W-1:0] phase;
   logic have_ref;
   logic in_window;
   logic early;
   logic setup_err;
   logic hold_err;
   logic setup_evt;
   logic hold_evt;
   logic cap_evt;
   logic wb_hit;
   logic wb_wr;
   logic [9:0] idx;
   logic [7:0] rd_data;
   logic [EVT_N-1:0] evt_set;

   ////////////////////////////////////////////////////////////////////////
   // Wishbone slave

   assign wb_hit = wb_i.cyc && wb_i.stb && !wb_o.ack;
   assign wb_wr = wb_hit && wb_i.we && wb_i.sel[0];
   assign idx = wb_i.adr[ADR_W-1:2];

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wb_o <= '0;
      end else begin
         wb_o.ack <= wb_hit;
         if (wb_hit && !wb_i.we) begin
            wb_o.dat <= {24'h000000, rd_data};
         end
      end
   end

   always_comb begin
      rd_data = 8'h00;
      if (idx == IDX_SETUP) begin
         rd_data[SETUP_FLAG_RST] = cfg.flag_rst;
         rd_data[SETUP_POL] = cfg.pol;
         rd_data[SETUP_EDGE] = cfg.edge_sel;
         rd_data[SETUP_MODE_LO +: 2] = cfg.mode;
      end else if (idx == IDX_IGNORE) begin
         rd_data[3:0] = ignore_cnt;
      end else if (idx == IDX_SKEW) begin
         rd_data[SKEW_NEG_LO +: 2] = skew_neg;
         rd_data[SKEW_POS_LO +: 2] = skew_pos;
      end else if (idx == IDX_STATE) begin
         rd_data = {have_ref, st == ST_DONE, st == ST_ARMED,
                    st == ST_RUN, 2'h0, hold_err, setup_err};
      end else if (idx == IDX_IRQ_STAT) begin
         rd_data[EVT_N-1:0] = irq_stat;
      end else if (idx == IDX_IRQ_MASK) begin
         rd_data[EVT_N-1:0] = irq_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg <= setup_type'(5'(SETUP_RST >> SETUP_MODE_LO));
      end else if (wb_wr && idx == IDX_SETUP) begin
         cfg.flag_rst <= wb_i.dat[SETUP_FLAG_RST];
         cfg.pol <= wb_i.dat[SETUP_POL];
         cfg.edge_sel <= wb_i.dat[SETUP_EDGE];
         cfg.mode <= mode_type'(wb_i.dat[SETUP_MODE_LO +: 2]);
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ignore_cnt <= IGNORE_RST;
      end else if (wb_wr && idx == IDX_IGNORE) begin
         ignore_cnt <= wb_i.dat[3:0];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         {skew_neg, skew_pos} <= SKEW_RST;
      end else if (wb_wr && idx == IDX_SKEW) begin
         skew_neg <= wb_i.dat[SKEW_NEG_LO +: 2];
         skew_pos <= wb_i.dat[SKEW_POS_LO +: 2];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_mask <= MASK_RST;
      end else if (wb_wr && idx == IDX_IRQ_MASK) begin
         irq_mask <= wb_i.dat[EVT_N-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin sampling and transition detection

   sysref_sync2 u_sync (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .async_i({conv_clk_i, sysref_i}),
      .sync_o(pins_s)
   );

   assign sysref_s = pins_s[0];
   assign conv_s = pins_s[1];

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         conv_d <= 1'b0;
      end else begin
         conv_d <= conv_s;
      end
   end

   // Sample on the chosen converter clock edge
   assign samp_en = cfg.edge_sel ? (conv_d && !conv_s)
                                 : (!conv_d && conv_s);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sref_prev <= 1'b0;
      end else if (samp_en) begin
         sref_prev <= sysref_s;
      end
   end

   assign transition = samp_en && (cfg.pol ? (sref_prev && !sysref_s)
                                   : (!sref_prev && sysref_s));

   ////////////////////////////////////////////////////////////////////////
   // Capture mode state machine

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= ST_IDLE;
      end else begin
         case (st)
            ST_IDLE: begin
               if (cfg.mode == MODE_CONT) begin
                  st <= ST_RUN;
               end else if (cfg.mode == MODE_SHOT) begin
                  st <= ST_ARMED;
               end
            end
            ST_RUN: begin
               if (cfg.mode != MODE_CONT) begin
                  st <= ST_IDLE;
               end
            end
            ST_ARMED: begin
               if (cfg.mode != MODE_SHOT) begin
                  st <= ST_IDLE;
               end else if (transition && ign_left == 4'h0) begin
                  st <= ST_DONE;
               end
            end
            default: begin
               if (cfg.mode != MODE_SHOT) begin
                  st <= ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ign_left <= IGNORE_RST;
      end else if (st != ST_ARMED) begin
         ign_left <= ignore_cnt;
      end else if (transition && ign_left != 4'h0) begin
         ign_left <= ign_left - 4'h1;
      end
   end

   assign cap = transition && (st == ST_RUN ||
                (st == ST_ARMED && ign_left == 4'h0));

   ////////////////////////////////////////////////////////////////////////
   // Alignment reference and skew windows

   sysref_skew_check u_skew (
      .phase_i(phase),
      .neg_i(skew_neg),
      .pos_i(skew_pos),
      .in_window_o(in_window),
      .early_o(early)
   );

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         phase <= '0;
         have_ref <= 1'b0;
      end else if (cap && (!have_ref || !in_window)) begin
         phase <= PHASE_AFTER_ALIGN;
         have_ref <= 1'b1;
      end else if (samp_en) begin
         phase <= phase + PHASE_AFTER_ALIGN;
      end
   end

   assign setup_evt = cap && have_ref && !in_window && early;
   assign hold_evt = cap && have_ref && !in_window && !early;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         setup_err <= 1'b0;
         hold_err <= 1'b0;
      end else if (cfg.flag_rst) begin
         setup_err <= 1'b0;
         hold_err <= 1'b0;
      end else begin
         setup_err <= setup_err || setup_evt;
         hold_err <= hold_err || hold_evt;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cap_evt <= 1'b0;
      end else begin
         cap_evt <= cap;
      end
   end

   assign capture_o = cap_evt;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status, write one to clear, set wins

   assign evt_set = {hold_evt, setup_evt, cap};

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_stat <= '0;
      end else if (wb_wr && idx == IDX_IRQ_STAT) begin
         irq_stat <= (irq_stat & ~wb_i.dat[EVT_N-1:0]) | evt_set;
      end else begin
         irq_stat <= irq_stat | evt_set;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   a_flag_reset_clear: assert property (
      @(posedge clk_i) disable iff (!arst_n_i)
      cfg.flag_rst |=> (!setup_err && !hold_err))
      else $error("error flags not cleared while held in reset");
   a_rise_capture: assert property (
      @(posedge clk_i) disable iff (!arst_n_i)
      (samp_en && !cfg.pol && !sref_prev && sysref_s && st == ST_RUN)
      |=> capture_o)
      else $error("rising transition not captured");
   a_fall_capture: assert property (
      @(posedge clk_i) disable iff (!arst_n_i)
      (samp_en && cfg.pol && sref_prev && !sysref_s && st == ST_RUN)
      |=> capture_o)
      else $error("falling transition not captured");
   a_wrong_polarity: assert property (
      @(posedge clk_i) disable iff (!arst_n_i)
      (samp_en && !cfg.pol && sref_prev && !sysref_s) |=> !capture_o)
      else $error("falling transition captured in rising mode");
   a_edge_sample: assert property (
      @(posedge clk_i) disable iff (!arst_n_i)
      samp_en |-> (cfg.edge_sel ? $fell(conv_s) : $rose(conv_s)))
      else $error("strobe sampled on the wrong clock edge");
   a_mode_off: assert property (
      @(posedge clk_i) disable iff (!arst_n_i)
      (cfg.mode == MODE_OFF)[*2] |=> !capture_o)
      else $error("capture while disabled");
   a_mode_enter: assert property (
      @(posedge clk_i) disable iff (!arst_n_i)
      (st == ST_IDLE && cfg.mode == MODE_CONT) |=> st == ST_RUN)
      else $error("continuous mode not entered");
   a_ignore_skip: assert property (
      @(posedge clk_i) disable iff (!arst_n_i)
      (st == ST_ARMED && cfg.mode == MODE_SHOT && transition
       && ign_left != 4'h0)
      |=> (!capture_o && ign_left == $past(ign_left) - 4'h1))
      else $error("ignored transition was captured");
   a_shot_hold: assert property (
      @(posedge clk_i) disable iff (!arst_n_i)
      (st == ST_DONE && cfg.mode == MODE_SHOT) |=> (st == ST_DONE
       && !capture_o))
      else $error("single shot captured again before re-arm");
   a_neg_tolerate: assert property (
      @(posedge clk_i) disable iff (!arst_n_i)
      (cap && have_ref && !cfg.flag_rst && phase != '0 &&
       ({1'b0, phase} + {3'h0, skew_neg}) >= PHASE_PERIOD)
      |=> (setup_err == $past(setup_err) && phase == $past(phase) + 4'h1))
      else $error("early transition inside window not tolerated");
   a_exact_alignment: assert property (
      @(posedge clk_i) disable iff (!arst_n_i)
      (cap && have_ref && !cfg.flag_rst && skew_neg == 2'h0
       && skew_pos == 2'h0 && phase != '0)
      |=> ((setup_err || hold_err) && phase == PHASE_AFTER_ALIGN))
      else $error("misaligned capture accepted with zero window");
   a_pos_tolerate: assert property (
      @(posedge clk_i) disable iff (!arst_n_i)
      (cap && have_ref && !cfg.flag_rst && phase != '0
       && phase <= {2'h0, skew_pos})
      |=> hold_err == $past(hold_err))
      else $error("late transition inside window not tolerated");
   a_pos_exceed: assert property (
      @(posedge clk_i) disable iff (!arst_n_i)
      (cap && have_ref && !cfg.flag_rst
       && phase == {2'h0, skew_pos} + 4'h1 && !phase[PHASE_W-1])
      |=> hold_err)
      else $error("late transition past window not flagged");
   a_irq_level: assert property (
      @(posedge clk_i) disable iff (!arst_n_i)
      |(irq_stat & irq_mask) |=> irq_o)
      else $error("interrupt not raised for unmasked status");
endmodule : sysref_capture_control

// *** core/sysref_pkg.sv ***
// Register map, field layout and shared types of the capture control
package sysref_pkg;
   localparam int ADR_W = 12;
   localparam int DAT_W = 32;
   // Register indexes; the byte address is four times the index
   localparam logic [9:0] IDX_SETUP = 10'h120;
   localparam logic [9:0] IDX_IGNORE = 10'h121;
   localparam logic [9:0] IDX_SKEW = 10'h122;
   localparam logic [9:0] IDX_STATE = 10'h130;
   localparam logic [9:0] IDX_IRQ_STAT = 10'h131;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h132;
   // Setup register fields
   localparam int SETUP_FLAG_RST = 6;
   localparam int SETUP_POL = 4;
   localparam int SETUP_EDGE = 3;
   localparam int SETUP_MODE_LO = 1;
   // Skew register fields
   localparam int SKEW_NEG_LO = 2;
   localparam int SKEW_POS_LO = 0;
   // Interrupt status bits
   localparam int EVT_CAPTURE = 0;
   localparam int EVT_SETUP = 1;
   localparam int EVT_HOLD = 2;
   localparam int EVT_N = 3;
   // Reset values
   localparam logic [7:0] SETUP_RST = 8'h00;
   localparam logic [3:0] IGNORE_RST = 4'h0;
   localparam logic [3:0] SKEW_RST = 4'h0;
   localparam logic [EVT_N-1:0] MASK_RST = 3'h0;
   // Alignment reference: sample clocks per reference period
   localparam int PHASE_W = 4;
   localparam logic [PHASE_W:0] PHASE_PERIOD = 5'h10;
   localparam logic [PHASE_W-1:0] PHASE_AFTER_ALIGN = 4'h1;

   typedef enum logic [1:0] {
      MODE_OFF,
      MODE_CONT,
      MODE_SHOT,
      MODE_SPARE
   } mode_type;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RUN,
      ST_ARMED,
      ST_DONE
   } cap_state_type;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ADR_W-1:0] adr;
      logic [3:0] sel;
      logic [DAT_W-1:0] dat;
   } wb_req_type;

   typedef struct packed {
      logic ack;
      logic [DAT_W-1:0] dat;
   } wb_rsp_type;

   typedef struct packed {
      logic flag_rst;
      logic pol;
      logic edge_sel;
      mode_type mode;
   } setup_type;
endpackage : sysref_pkg

// *** core/sysref_sync2.sv ***
// Two-flop synchroniser for the strobe and converter clock pins
`timescale 1ns/1ps
module sysref_sync2 (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [1:0] async_i,
   output logic [1:0] sync_o
);
   logic [1:0] meta;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta <= 2'h0;
         sync_o <= 2'h0;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end
endmodule : sysref_sync2

// *** core/sysref_skew_check.sv ***
// Judges a captured transition against the skew windows
`timescale 1ns/1ps
module sysref_skew_check
   import sysref_pkg::*;
(
   input wire logic [PHASE_W-1:0] phase_i,
   input wire logic [1:0] neg_i,
   input wire logic [1:0] pos_i,
   output logic in_window_o,
   output logic early_o
);
   logic [PHASE_W:0] ahead;

   always_comb begin
      ahead = PHASE_PERIOD - {1'b0, phase_i};
      early_o = phase_i[PHASE_W-1];
      in_window_o = 1'b0;
      if (phase_i == '0) begin
         in_window_o = 1'b1;
      end else if (early_o) begin
         in_window_o = (ahead <= {3'h0, neg_i});
      end else begin
         in_window_o = (phase_i <= {2'h0, pos_i});
      end
   end
endmodule : sysref_skew_check

// *** dv/sysref_source.sv ***
// Model of the clock source driving the converter clock and the strobe
`timescale 1ns/1ps
module sysref_source (
   input wire logic clk_i,
   input wire logic inv_i,
   output logic conv_clk_o,
   output logic sysref_o
);
   int div = 0;
   int n_edge = 0;
   int last = 0;
   logic act = 1'b0;

   initial begin
      conv_clk_o = 1'b0;
      sysref_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Converter clock: eight system clocks per period, counted on its rise
   always @(posedge clk_i) begin
      div <= (div + 1) % 4;
      if (div == 3) begin
         conv_clk_o <= ~conv_clk_o;
         if (!conv_clk_o) begin
            n_edge <= n_edge + 1;
         end
      end
   end

   // Idle level follows the chosen polarity; a pulse inverts it
   always @(posedge clk_i) begin
      sysref_o <= inv_i ^ act;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic start();
      last = n_edge;
   endtask : start

   // Pulse one converter period wide, launched a fixed phase after a rise
   task automatic pulse(input int gap);
      wait (n_edge == last + gap);
      repeat (2) @(posedge clk_i);
      act <= 1'b1;
      last = n_edge;
      wait (n_edge == last + 1);
      repeat (2) @(posedge clk_i);
      act <= 1'b0;
   endtask : pulse
endmodule : sysref_source

// *** dv/tb_top.sv ***
// Self-checking bench for the strobe capture control
`timescale 1ns/1ps
module tb_top;
   import sysref_pkg::*;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   wb_req_type wb_i = '0;
   wb_rsp_type wb_o;
   logic sysref;
   logic conv;
   logic capture_o;
   logic irq_o;
   logic inv = 1'b0;
   logic sr_q = 1'b0;
   logic [31:0] rd;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;
   int n_cap = 0;
   int cap_at = 0;
   int sr_at = 0;

   always #2 clk_i = ~clk_i;

   sysref_capture_control uut (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .wb_i(wb_i), .wb_o(wb_o), .sysref_i(sysref), .conv_clk_i(conv),
      .capture_o(capture_o), .irq_o(irq_o));
   sysref_source src (.clk_i(clk_i), .inv_i(inv), .conv_clk_o(conv),
      .sysref_o(sysref));

   // Counts captures, stamps active strobe edges, cuts a hang short
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      sr_q <= sysref;
      if (capture_o === 1'b1) begin
         n_cap <= n_cap + 1;
         cap_at <= cycles;
      end
      if (sysref !== sr_q && sysref !== inv) begin
         sr_at <= cycles;
      end
      if (cycles == 20000) begin
         n_errors++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic wb(input logic we, input logic [9:0] idx,
                     input logic [7:0] d);
      @(posedge clk_i);
      wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00},
                sel: 4'hF, dat: {24'h000000, d}};
      @(posedge clk_i);
      while (wb_o.ack !== 1'b1) @(posedge clk_i);
      rd = wb_o.dat;
      wb_i <= '0;
   endtask : wb

   task automatic setup(input logic [7:0] v);
      wb(1'b1, IDX_SETUP, v);
   endtask : setup

   task automatic fire(input int gap);
      src.pulse(gap);
      repeat (12) @(posedge clk_i);
   endtask : fire

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [9:0] ix [7] = '{IDX_SETUP, IDX_IGNORE, IDX_SKEW, IDX_STATE,
                             IDX_IRQ_STAT, IDX_IRQ_MASK, 10'h1FF};
      logic [7:0] wv [7] = '{8'h5E, 8'h0F, 8'h0F, 8'h00, 8'h00, 8'h07, 8'h00};
      for (int i = 0; i < 7; i++) begin
         wb(1'b0, ix[i], 8'h00);
         chk_reg(rd, 32'h0);
         wb(1'b1, ix[i], 8'hFF);
         wb(1'b0, ix[i], 8'h00);
         chk_reg(rd, {24'h000000, wv[i]});
         wb(1'b1, ix[i], 8'h00);
      end
   endtask : t_regs

   task automatic t_modes();
      logic [7:0] md [3] = '{8'h00, 8'h06, 8'h02};
      int ex [3] = '{0, 0, 2};
      int c;
      for (int i = 0; i < 3; i++) begin
         setup(md[i]);
         src.start();
         c = n_cap;
         fire(2);
         fire(16);
         chk_reg(32'(n_cap - c), 32'(ex[i]));
      end
   endtask : t_modes

   task automatic t_poledge();
      int lat;
      for (int i = 0; i < 4; i++) begin
         setup({3'b000, i[0], i[1], 3'b000});
         inv <= i[0];
         repeat (4) @(posedge clk_i);
         setup({3'b000, i[0], i[1], 3'b010});
         src.start();
         fire(2);
         lat = cap_at - sr_at;
         chk_bit(i[1] ? (lat >= 2 && lat <= 6) : (lat >= 7 && lat <= 11),
                 1'b1);
      end
      setup(8'h00);
      inv <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : t_poledge

   // Bits 5:4 expected hold and setup errors, bits 3:0 the skew setting
   task automatic t_skew();
      logic [5:0] tc [13] = '{6'h00, 6'h20, 6'h10, 6'h01, 6'h01, 6'h03,
         6'h03, 6'h22, 6'h04, 6'h04, 6'h0C, 6'h0C, 6'h18};
      int gp [13] = '{16, 17, 15, 17, 15, 19, 13, 19, 15, 17, 13, 19, 13};
      setup(8'h02);
      src.start();
      fire(2);
      for (int i = 0; i < 13; i++) begin
         wb(1'b1, IDX_SKEW, {4'h0, tc[i][3:0]});
         setup(8'h42);
         wb(1'b0, IDX_STATE, 8'h00);
         chk_reg(rd & 32'h3, 32'h0);
         setup(8'h02);
         wb(1'b1, IDX_IRQ_STAT, 8'h07);
         fire(gp[i]);
         wb(1'b0, IDX_STATE, 8'h00);
         chk_reg(rd & 32'h3, {30'h0, tc[i][5:4]});
         wb(1'b0, IDX_IRQ_STAT, 8'h00);
         chk_reg(rd, {29'h0, tc[i][5:4], 1'b1});
      end
   endtask : t_skew

   task automatic t_shot();
      int c;
      for (int n = 0; n < 16; n += 15) begin
         setup(8'h00);
         wb(1'b1, IDX_IGNORE, 8'(n));
         setup(8'h04);
         src.start();
         c = n_cap;
         repeat (n) fire(16);
         chk_reg(32'(n_cap - c), 32'h0);
         fire(16);
         chk_reg(32'(n_cap - c), 32'h1);
         fire(16);
         fire(16);
         chk_reg(32'(n_cap - c), 32'h1);
      end
   endtask : t_shot

   task automatic t_irq();
      wb(1'b1, IDX_IRQ_STAT, 8'h07);
      wb(1'b1, IDX_IRQ_MASK, 8'h01);
      repeat (2) @(posedge clk_i);
      chk_bit(irq_o, 1'b0);
      setup(8'h02);
      src.start();
      fire(2);
      chk_bit(irq_o, 1'b1);
      wb(1'b1, IDX_IRQ_MASK, 8'h00);
      repeat (2) @(posedge clk_i);
      chk_bit(irq_o, 1'b0);
      wb(1'b1, IDX_IRQ_MASK, 8'h07);
      repeat (2) @(posedge clk_i);
      chk_bit(irq_o, 1'b1);
      wb(1'b1, IDX_IRQ_STAT, 8'h07);
      repeat (2) @(posedge clk_i);
      chk_bit(irq_o, 1'b0);
      setup(8'h00);
   endtask : t_irq

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("errors=%0d checks=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   initial begin
      repeat (16) @(posedge clk_i);
      arst_n_i <= 1'b1;
      t_regs();
      t_modes();
      t_poledge();
      t_skew();
      t_shot();
      t_irq();
      end_sim();
   end
endmodule : tb_top
